// [core/bridge_sec_map.vh]
// register offsets, field positions and reset values of the bridge register window
`ifndef BRIDGE_SEC_MAP_VH
`define BRIDGE_SEC_MAP_VH

// ==========================================
// window sizes (bytes)
`define SEC_CTRL_WIN_BYTES 16'h8000
`define PRI_CTRL_WIN_BYTES 17'h10000

// ==========================================
// 64-bit registers, eight bytes apart from offset 0
`define WIDE_BASE 16'h0000
`define WIDE_COUNT 11
`define K_PRI_WIN2_LIMIT 4'h0
`define K_PRI_WIN4_LIMIT 4'h1
`define K_SEC_WIN2_LIMIT 4'h2
`define K_SEC_WIN4_LIMIT 4'h3
`define K_PRI_WIN2_XLAT 4'h4
`define K_PRI_WIN4_XLAT 4'h5
`define K_SEC_WIN2_XLAT 4'h6
`define K_SEC_WIN4_XLAT 4'h7
`define K_SEC_WIN0_BASE 4'h8
`define K_SEC_WIN2_BASE 4'h9
`define K_SEC_WIN4_BASE 4'hA

// ==========================================
// 32-bit registers
`define OFF_BRIDGE_CONTROL 16'h0058
`define OFF_PRI_DOORBELL 16'h0060
`define OFF_SEC_DOORBELL 16'h0064
`define OFF_PRI_DB_MASK 16'h0068
`define OFF_SEC_DB_MASK 16'h006C
`define OFF_SEMAPHORE 16'h0080
`define OFF_SCRATCH 16'h0100
`define OFF_PEER_DOORBELL 16'h0140
`define OFF_PEER_SCRATCH 16'h0180

// ==========================================
// bridge control fields
`define BC_SNOOP_OFF_WIN2 0
`define BC_SNOOP_OFF_WIN4 1
`define BC_LINK_DISABLE 2
`define BC_SEC_CFG_LOCK 3
`define BC_STRAP_OVR_EN 4
`define BC_STRAP_OVR_UP 5
`define BC_SEC_WR_MASK 32'h0000_0003
`define BC_RESET 32'h0000_0000

// ==========================================
// doorbell fields and resets
`define DB_SW_BITS 16'h3FFF
`define DB_FLUSH_BIT 14
`define DB_LINK_BIT 15
`define DB_RESET 16'h0000
`define DB_MASK_RESET 16'h0000

// ==========================================
// window size exponents and the 32-bit address limit
`define WIN_LOG2_MIN 6'h0C
`define WIN_LOG2_MAX 6'h27
`define ADDR_32_LIMIT 64'h0000_0000_FFFF_FFFF

`endif

// [core/scratch_mem.v]
// scratchpad word store with registered read data
`timescale 1ns/1ps

module scratch_mem #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter DW = 32
) (
    input wire i_sys_clk,
    input wire i_ce,
    input wire i_wr,
    input wire [AW-1:0] i_addr,
    input wire [DW-1:0] i_wdata,
    output reg [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // ==========================================
    // one access per cycle; a write cycle also reads the old word into o_rdata
    always @(posedge i_sys_clk) begin
        if (i_ce) begin
            if (i_wr) begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// [core/bridge_sec.v]
// secondary register window, doorbells, semaphore and inbound translation of the bridge
`timescale 1ns/1ps
`include "bridge_sec_map.vh"

// How it works
// - secondary control window decodes a fixed 32KB region; beyond it errors.
// - secondary writes to primary-controlling registers are dropped, except the primary translates and the primary doorbell mask.
// - accesses above a programmed nonzero limit are rejected even inside window.
// - secondary window limits are writable from both sides.
// - secondary writes to bridge control only change the snoop bits.
// - primary writes to base mirrors change the real secondary window bases.
// - primary windows 2/3 and 4/5 forward using the primary translate registers.
// - secondary writes set primary doorbell bits 13:0, raising primary interrupt.
// - flush completion sets primary doorbell bit 14.
// - every link state change sets primary doorbell bit 15.
// - primary writes to secondary doorbell raise the secondary interrupt.
// - writing one sets a doorbell bit; receiving side writes one to clear.
// - a mask bit at one blocks that doorbell bit's interrupt.
// - sixteen 32-bit scratchpads readable and writable from both sides.
// - semaphore read returns value then sets; zero means ownership granted.
// - writing one to the semaphore clears it; owner releases this way.
// - scratchpad writes never depend on semaphore state.
// - secondary windows accept any power-of-two size from 4KB to 512GB.
// - secondary hit forwards translate plus offset from the window base.
// - forwarded packets get new requester id and 3 or 4 dword header.
// - peer doorbell and scratchpad writes emit a write toward the peer.
// - direction from strap or override, frozen while the link is up.
module bridge_sec #(
    parameter SPAD_COUNT = 16,
    parameter SPAD_AW = 4
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_reg_valid,
    input wire i_reg_write,
    input wire i_reg_from_sec,
    input wire [16:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    output reg o_reg_ack,
    output reg o_reg_err,
    output wire [31:0] o_reg_rdata,
    input wire [5:0] i_pri_win2_log2,
    input wire [5:0] i_pri_win4_log2,
    input wire [5:0] i_sec_win2_log2,
    input wire [5:0] i_sec_win4_log2,
    input wire [63:0] i_pri_win2_base,
    input wire [63:0] i_pri_win4_base,
    input wire [15:0] i_pri_id,
    input wire [15:0] i_sec_id,
    input wire i_tlp_valid,
    input wire i_tlp_from_sec,
    input wire [63:0] i_tlp_addr,
    output reg o_fwd_valid,
    output reg [63:0] o_fwd_addr,
    output reg o_fwd_4dw,
    output reg [15:0] o_fwd_req_id,
    output reg o_fwd_snoop_off,
    output reg o_ur_valid,
    output reg o_peer_valid,
    output reg [63:0] o_peer_addr,
    output reg [31:0] o_peer_data,
    input wire i_flush_done,
    input wire i_link_up,
    input wire i_strap_upstream,
    output reg o_port_upstream,
    output wire o_link_enable,
    output wire o_sec_cfg_lock,
    output wire [63:0] o_sec_win0_base,
    output wire [63:0] o_sec_win2_base,
    output wire [63:0] o_sec_win4_base,
    output wire o_pri_irq,
    output wire o_sec_irq
);
    localparam [3:0] CLS_NONE = 4'h0, CLS_WIDE = 4'h1, CLS_CTRL = 4'h2, CLS_PDB = 4'h3, CLS_SDB = 4'h4,
        CLS_PMASK = 4'h5, CLS_SMASK = 4'h6, CLS_SEMA = 4'h7, CLS_SPAD = 4'h8,
        CLS_PEER_DB = 4'h9, CLS_PEER_SPAD = 4'hA;

    // ==========================================
    // decoding helpers
    function [3:0] reg_class;
        input [15:0] off;
        begin
            if (off < (`WIDE_BASE + 16'h0058)) begin
                reg_class = CLS_WIDE;
            end else if (off == `OFF_BRIDGE_CONTROL) begin
                reg_class = CLS_CTRL;
            end else if (off == `OFF_PRI_DOORBELL) begin
                reg_class = CLS_PDB;
            end else if (off == `OFF_SEC_DOORBELL) begin
                reg_class = CLS_SDB;
            end else if (off == `OFF_PRI_DB_MASK) begin
                reg_class = CLS_PMASK;
            end else if (off == `OFF_SEC_DB_MASK) begin
                reg_class = CLS_SMASK;
            end else if (off == `OFF_SEMAPHORE) begin
                reg_class = CLS_SEMA;
            end else if (off >= `OFF_SCRATCH && off < `OFF_PEER_DOORBELL) begin
                reg_class = CLS_SPAD;
            end else if (off == `OFF_PEER_DOORBELL) begin
                reg_class = CLS_PEER_DB;
            end else if (off >= `OFF_PEER_SCRATCH && off < (`OFF_PEER_SCRATCH + 16'h0040)) begin
                reg_class = CLS_PEER_SPAD;
            end else begin
                reg_class = CLS_NONE;
            end
        end
    endfunction

    // low address bits covered by a window, exponent clamped to the legal range
    function [63:0] win_mask;
        input [5:0] log2;
        reg [5:0] n;
        begin
            n = log2;
            if (n < `WIN_LOG2_MIN) begin
                n = `WIN_LOG2_MIN;
            end else if (n > `WIN_LOG2_MAX) begin
                n = `WIN_LOG2_MAX;
            end
            win_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << n);
        end
    endfunction

    // wide registers the secondary side may write
    function sec_may_write;
        input [3:0] k;
        begin
            sec_may_write = (k == `K_SEC_WIN2_LIMIT) || (k == `K_SEC_WIN4_LIMIT) ||
                            (k == `K_PRI_WIN2_XLAT) || (k == `K_PRI_WIN4_XLAT);
        end
    endfunction

    // ==========================================
    // register state
    reg [63:0] wide [0:`WIDE_COUNT-1];
    reg [31:0] bridge_control, rd_reg;
    reg [15:0] primary_doorbell, secondary_doorbell, primary_doorbell_mask, secondary_doorbell_mask;
    reg scratchpad_semaphore, rd_spad;
    reg link_meta, link_sync, link_prev, strap_meta, strap_sync;
    wire [31:0] spad_rdata;
    integer i;

    // ==========================================
    // request decode
    wire [15:0] off = i_reg_addr[15:0];
    wire [3:0] cls = reg_class(off);
    wire [3:0] k = off[6:3];
    wire out_of_win = i_reg_from_sec ? (i_reg_addr >= {1'b0, `SEC_CTRL_WIN_BYTES}) : 1'b0;
    wire bad = (cls == CLS_NONE) || out_of_win;
    wire take = i_reg_valid && !bad;
    wire wr = take && i_reg_write;
    wire rd = take && !i_reg_write;
    wire pri_wr = wr && !i_reg_from_sec;
    wire sec_wr = wr && i_reg_from_sec;
    wire link_change = link_sync ^ link_prev;

    // ==========================================
    // doorbell set and clear terms, a set wins over a clear in the same cycle
    wire [15:0] pdb_set = ((sec_wr && cls == CLS_PDB) ? (i_reg_wdata[15:0] & `DB_SW_BITS) : 16'h0000) |
                          ({15'h0000, i_flush_done} << `DB_FLUSH_BIT) |
                          ({15'h0000, link_change} << `DB_LINK_BIT);
    wire [15:0] pdb_clr = (pri_wr && cls == CLS_PDB) ? i_reg_wdata[15:0] : 16'h0000;
    wire [15:0] sdb_set = (pri_wr && cls == CLS_SDB) ? i_reg_wdata[15:0] : 16'h0000;
    wire [15:0] sdb_clr = (sec_wr && cls == CLS_SDB) ? i_reg_wdata[15:0] : 16'h0000;

    // ==========================================
    // interrupt outputs gated by masks
    assign o_pri_irq = |(primary_doorbell & ~primary_doorbell_mask);
    assign o_sec_irq = |(secondary_doorbell & ~secondary_doorbell_mask);
    assign o_link_enable = !bridge_control[`BC_LINK_DISABLE];
    assign o_sec_cfg_lock = bridge_control[`BC_SEC_CFG_LOCK];
    assign o_sec_win0_base = wide[`K_SEC_WIN0_BASE];
    assign o_sec_win2_base = wide[`K_SEC_WIN2_BASE];
    assign o_sec_win4_base = wide[`K_SEC_WIN4_BASE];
    assign o_reg_rdata = rd_spad ? spad_rdata : rd_reg;

    // ==========================================
    // pin synchronisers and strap capture
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            link_prev <= 1'b0;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
            o_port_upstream <= 1'b0;
        end else if (i_ce) begin
            link_meta <= i_link_up;
            link_sync <= link_meta;
            link_prev <= link_sync;
            strap_meta <= i_strap_upstream;
            strap_sync <= strap_meta;
            if (!link_sync) begin
                o_port_upstream <= bridge_control[`BC_STRAP_OVR_EN] ?
                                   bridge_control[`BC_STRAP_OVR_UP] : strap_sync;
            end
        end
    end

    // ==========================================
    // register writes and side effects
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (i = 0; i < `WIDE_COUNT; i = i + 1) begin
                wide[i] <= 64'h0000_0000_0000_0000;
            end
            bridge_control <= `BC_RESET;
            primary_doorbell <= `DB_RESET;
            secondary_doorbell <= `DB_RESET;
            primary_doorbell_mask <= `DB_MASK_RESET;
            secondary_doorbell_mask <= `DB_MASK_RESET;
            scratchpad_semaphore <= 1'b0;
        end else if (i_ce) begin
            primary_doorbell <= (primary_doorbell & ~pdb_clr) | pdb_set;
            secondary_doorbell <= (secondary_doorbell & ~sdb_clr) | sdb_set;
            if (wr && cls == CLS_WIDE && (pri_wr || sec_may_write(k))) begin
                if (off[2]) begin
                    wide[k][63:32] <= i_reg_wdata;
                end else begin
                    wide[k][31:0] <= i_reg_wdata;
                end
            end
            if (pri_wr && cls == CLS_CTRL) begin
                bridge_control <= i_reg_wdata;
            end else if (sec_wr && cls == CLS_CTRL) begin
                bridge_control <= (bridge_control & ~`BC_SEC_WR_MASK) | (i_reg_wdata & `BC_SEC_WR_MASK);
            end
            if (wr && cls == CLS_PMASK) begin
                primary_doorbell_mask <= i_reg_wdata[15:0];
            end
            if (wr && cls == CLS_SMASK) begin
                secondary_doorbell_mask <= i_reg_wdata[15:0];
            end
            if (rd && cls == CLS_SEMA) begin
                scratchpad_semaphore <= 1'b1;
            end else if (wr && cls == CLS_SEMA && i_reg_wdata[0]) begin
                scratchpad_semaphore <= 1'b0;
            end
        end
    end

    // ==========================================
    // read data and completion, one cycle after the request
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_ack <= 1'b0;
            o_reg_err <= 1'b0;
            rd_reg <= 32'h0000_0000;
            rd_spad <= 1'b0;
        end else if (i_ce) begin
            o_reg_ack <= i_reg_valid;
            o_reg_err <= i_reg_valid && bad;
            rd_spad <= rd && cls == CLS_SPAD;
            if (rd) begin
                if (cls == CLS_WIDE) begin
                    rd_reg <= off[2] ? wide[k][63:32] : wide[k][31:0];
                end else if (cls == CLS_CTRL) begin
                    rd_reg <= bridge_control;
                end else if (cls == CLS_PDB) begin
                    rd_reg <= {16'h0000, primary_doorbell};
                end else if (cls == CLS_SDB) begin
                    rd_reg <= {16'h0000, secondary_doorbell};
                end else if (cls == CLS_PMASK) begin
                    rd_reg <= {16'h0000, primary_doorbell_mask};
                end else if (cls == CLS_SMASK) begin
                    rd_reg <= {16'h0000, secondary_doorbell_mask};
                end else if (cls == CLS_SEMA) begin
                    rd_reg <= {31'h0000_0000, scratchpad_semaphore};
                end else begin
                    rd_reg <= 32'h0000_0000;
                end
            end else begin
                rd_reg <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // shared scratchpads, written regardless of the semaphore
    scratch_mem #(
        .DEPTH(SPAD_COUNT),
        .AW(SPAD_AW),
        .DW(32)
    ) u_spad (
        .i_sys_clk(i_sys_clk),
        .i_ce(i_ce),
        .i_wr(wr && cls == CLS_SPAD),
        .i_addr(off[SPAD_AW+1:2]),
        .i_wdata(i_reg_wdata),
        .o_rdata(spad_rdata)
    );

    // ==========================================
    // peer forwarding of doorbell and scratchpad writes
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_peer_valid <= 1'b0;
            o_peer_addr <= 64'h0;
            o_peer_data <= 32'h0;
        end else if (i_ce) begin
            o_peer_valid <= wr && (cls == CLS_PEER_DB || cls == CLS_PEER_SPAD);
            if (wr && cls == CLS_PEER_DB) begin
                o_peer_addr <= wide[`K_SEC_WIN0_BASE] + {48'h0, `OFF_PRI_DOORBELL};
                o_peer_data <= i_reg_wdata;
            end else if (wr && cls == CLS_PEER_SPAD) begin
                o_peer_addr <= wide[`K_SEC_WIN0_BASE] +
                               {48'h0, `OFF_SCRATCH + (off - `OFF_PEER_SCRATCH)};
                o_peer_data <= i_reg_wdata;
            end
        end
    end

    // ==========================================
    // inbound window match, limit check and translation
    reg hit2, hit4, over;
    reg [63:0] m2, m4, b2, b4, lim, xl, ofs, next_addr;

    always @* begin
        m2 = i_tlp_from_sec ? win_mask(i_sec_win2_log2) : win_mask(i_pri_win2_log2);
        m4 = i_tlp_from_sec ? win_mask(i_sec_win4_log2) : win_mask(i_pri_win4_log2);
        b2 = i_tlp_from_sec ? wide[`K_SEC_WIN2_BASE] : i_pri_win2_base;
        b4 = i_tlp_from_sec ? wide[`K_SEC_WIN4_BASE] : i_pri_win4_base;
        hit2 = ((i_tlp_addr & ~m2) == (b2 & ~m2));
        hit4 = !hit2 && ((i_tlp_addr & ~m4) == (b4 & ~m4));
        if (hit2) begin
            lim = i_tlp_from_sec ? wide[`K_SEC_WIN2_LIMIT] : wide[`K_PRI_WIN2_LIMIT];
            xl = i_tlp_from_sec ? wide[`K_SEC_WIN2_XLAT] : wide[`K_PRI_WIN2_XLAT];
            ofs = i_tlp_addr & m2;
        end else begin
            lim = i_tlp_from_sec ? wide[`K_SEC_WIN4_LIMIT] : wide[`K_PRI_WIN4_LIMIT];
            xl = i_tlp_from_sec ? wide[`K_SEC_WIN4_XLAT] : wide[`K_PRI_WIN4_XLAT];
            ofs = i_tlp_addr & m4;
        end
        over = (lim != 64'h0) && (i_tlp_addr > lim);
        next_addr = xl + ofs;
    end

    // ==========================================
    // forward or complete as unsupported request
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwd_valid <= 1'b0;
            o_fwd_addr <= 64'h0;
            o_fwd_4dw <= 1'b0;
            o_fwd_req_id <= 16'h0000;
            o_fwd_snoop_off <= 1'b0;
            o_ur_valid <= 1'b0;
        end else if (i_ce) begin
            o_fwd_valid <= i_tlp_valid && (hit2 || hit4) && !over;
            o_ur_valid <= i_tlp_valid && (!(hit2 || hit4) || over);
            if (i_tlp_valid && (hit2 || hit4) && !over) begin
                o_fwd_addr <= next_addr;
                o_fwd_4dw <= next_addr > `ADDR_32_LIMIT;
                o_fwd_req_id <= i_tlp_from_sec ? i_pri_id : i_sec_id;
                o_fwd_snoop_off <= i_tlp_from_sec &&
                                   (hit2 ? bridge_control[`BC_SNOOP_OFF_WIN2] : bridge_control[`BC_SNOOP_OFF_WIN4]);
            end
        end
    end
endmodule

// [bench/bridge_sec_asserts.sv]
// checker of register, forward and peer port timing of the bridge
`timescale 1ns/1ps
module bridge_sec_checker (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_reg_valid,
    input wire i_reg_write,
    input wire i_reg_from_sec,
    input wire [16:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire o_reg_ack,
    input wire o_reg_err,
    input wire [15:0] i_pri_id,
    input wire [15:0] i_sec_id,
    input wire i_tlp_valid,
    input wire i_tlp_from_sec,
    input wire o_fwd_valid,
    input wire [63:0] o_fwd_addr,
    input wire o_fwd_4dw,
    input wire [15:0] o_fwd_req_id,
    input wire o_ur_valid,
    input wire o_peer_valid,
    input wire [31:0] o_peer_data,
    input wire o_link_enable,
    input wire [63:0] o_sec_win2_base
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // request qualifiers
    wire req = i_ce && i_reg_valid;
    wire wr = req && i_reg_write;
    property p_sec_range; req && i_reg_from_sec && i_reg_addr >= 17'h08000 |=> o_reg_ack && o_reg_err; endproperty
    a_sec_range: assert property (p_sec_range) else $error("secondary offset past window not refused");
    property p_ack_cause; o_reg_ack |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("completion without request");
    property p_one_answer; i_ce && i_tlp_valid |=> o_fwd_valid != o_ur_valid; endproperty
    a_one_answer: assert property (p_one_answer) else $error("inbound request not answered once");
    property p_req_id;
        o_fwd_valid |-> o_fwd_req_id == ($past(i_tlp_from_sec) ? $past(i_pri_id) : $past(i_sec_id));
    endproperty
    a_req_id: assert property (p_req_id) else $error("forward requester id wrong");
    property p_four_dw; o_fwd_valid |-> o_fwd_4dw == (o_fwd_addr > 64'h0000_0000_FFFF_FFFF); endproperty
    a_four_dw: assert property (p_four_dw) else $error("header length wrong");
    property p_peer; wr && i_reg_addr == 17'h00140 |=> o_peer_valid && o_peer_data == $past(i_reg_wdata); endproperty
    a_peer: assert property (p_peer) else $error("peer doorbell write not emitted");
    property p_peer_cause; o_peer_valid |-> $past(wr); endproperty
    a_peer_cause: assert property (p_peer_cause) else $error("peer write without cause");
    property p_link_en; $fell(o_link_enable) |-> $past(wr && !i_reg_from_sec && i_reg_addr == 17'h00058); endproperty
    a_link_en: assert property (p_link_en) else $error("link disabled without primary write");
    property p_base; $changed(o_sec_win2_base) |-> $past(wr && !i_reg_from_sec); endproperty
    a_base: assert property (p_base) else $error("window base changed without primary write");
    c_fwd: cover property (o_fwd_valid && o_fwd_4dw);
    c_ur: cover property (o_ur_valid);
    c_peer: cover property (o_peer_valid);
endmodule
bind bridge_sec bridge_sec_checker u_bridge_sec_checker (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_reg_valid(i_reg_valid), .i_reg_write(i_reg_write), .i_reg_from_sec(i_reg_from_sec), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err), .i_pri_id(i_pri_id), .i_sec_id(i_sec_id),
    .i_tlp_valid(i_tlp_valid), .i_tlp_from_sec(i_tlp_from_sec), .o_fwd_valid(o_fwd_valid), .o_fwd_addr(o_fwd_addr),
    .o_fwd_4dw(o_fwd_4dw), .o_fwd_req_id(o_fwd_req_id), .o_ur_valid(o_ur_valid), .o_peer_valid(o_peer_valid),
    .o_peer_data(o_peer_data), .o_link_enable(o_link_enable), .o_sec_win2_base(o_sec_win2_base));

// [bench/link_peer_model.sv]
// far-end model: link state pin and cache flush completion pulse
`timescale 1ns/1ps
module link_peer_model (
    input wire i_sys_clk,
    input wire i_train,
    input wire i_flush_req,
    output reg o_link_up = 1'b0,
    output reg o_flush_done = 1'b0
);
    // ==========================================
    // link state follows training, out of phase with the clock
    always @(i_train) begin
        #3 o_link_up = i_train;
    end
    // flush completion as a single-cycle pulse
    always @(posedge i_sys_clk) begin
        o_flush_done <= i_flush_req && !o_flush_done;
    end
endmodule

// [bench/bridge_sec_bench.sv]
// self-checking bench of the bridge register window and inbound translation
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module bridge_sec_bench;
    reg clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0, sec = 1'b0, tv = 1'b0, tsec = 1'b0;
    reg strap = 1'b1, train = 1'b0, flush_req = 1'b0;
    reg [16:0] addr = 17'h00000;
    reg [31:0] wdata = 32'h00000000, rd;
    reg [63:0] taddr = 64'h0, pb2 = 64'h40000;
    reg [15:0] pid = 16'hA100, sid = 16'hB200;
    reg [5:0] s2_log2 = 6'h0C, s4_log2 = 6'h27;
    wire ack, err, fwd_v, f4, sn, ur, pv, up, link_en, pirq, sirq, link_up, flush_done, lock;
    wire [31:0] rdata, pdata;
    wire [15:0] rid;
    wire [63:0] faddr, paddr, b2;
    integer err_count = 0, checks = 0;
    // ==========================================
    // design, far-end model and clock
    bridge_sec u_bridge_sec (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_reg_valid(valid), .i_reg_write(wr),
        .i_reg_from_sec(sec), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_ack(ack), .o_reg_err(err),
        .o_reg_rdata(rdata), .i_pri_win2_log2(6'h10), .i_pri_win4_log2(6'h0C), .i_sec_win2_log2(s2_log2),
        .i_sec_win4_log2(s4_log2), .i_pri_win2_base(pb2), .i_pri_win4_base(64'h0), .i_pri_id(pid), .i_sec_id(sid),
        .i_tlp_valid(tv), .i_tlp_from_sec(tsec), .i_tlp_addr(taddr), .o_fwd_valid(fwd_v), .o_fwd_addr(faddr),
        .o_fwd_4dw(f4), .o_fwd_req_id(rid), .o_fwd_snoop_off(sn), .o_ur_valid(ur), .o_peer_valid(pv),
        .o_peer_addr(paddr), .o_peer_data(pdata), .i_flush_done(flush_done), .i_link_up(link_up),
        .i_strap_upstream(strap), .o_port_upstream(up), .o_link_enable(link_en), .o_sec_cfg_lock(lock),
        .o_sec_win0_base(), .o_sec_win2_base(b2), .o_sec_win4_base(), .o_pri_irq(pirq), .o_sec_irq(sirq));
    link_peer_model u_link_peer_model (.i_sys_clk(clk), .i_train(train), .i_flush_req(flush_req),
        .o_link_up(link_up), .o_flush_done(flush_done));
    always #5 clk = ~clk;
    // ==========================================
    // register access, answer sampled in the ack cycle
    task acc(input s, input w, input [16:0] a, input [31:0] d);
        begin
            @(negedge clk);
            valid = 1'b1;
            wr = w;
            sec = s;
            addr = a;
            wdata = d;
            @(negedge clk);
            valid = 1'b0;
            rd = rdata;
            `CHK("ack", 1'b1, ack)
        end
    endtask
    // inbound request, answer sampled one cycle later
    task tlp(input s, input [63:0] a);
        begin
            @(negedge clk);
            tv = 1'b1;
            tsec = s;
            taddr = a;
            @(negedge clk);
            tv = 1'b0;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d err_count %0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        #100000;
        err_count++;
        give_verdict;
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("strap", 1'b1, up)
        acc(0, 1, 17'h58, 32'h14);
        repeat (4) @(negedge clk);
        `CHK("override", 1'b0, up)
        acc(0, 1, 17'h00, 32'h4FFFF);
        acc(1, 1, 17'h00, 32'hFFFF);
        acc(1, 0, 17'h00, 32'h0);
        `CHK("pri_lim", 32'h4FFFF, rd)
        acc(1, 1, 17'h10, 32'h00100FFF);
        acc(0, 0, 17'h10, 32'h0);
        `CHK("sec_lim", 32'h00100FFF, rd)
        acc(0, 1, 17'h48, 32'h00100000);
        `CHK("base2", 64'h100000, b2)
        acc(0, 1, 17'h54, 32'h80);
        acc(0, 1, 17'h30, 32'h00800000);
        acc(0, 1, 17'h40, 32'h00200000);
        acc(1, 1, 17'h58, 32'h3B);
        acc(0, 0, 17'h58, 32'h0);
        `CHK("ctrl", 32'h17, rd)
        `CHK("link_en", 1'b0, link_en)
        `CHK("cfg_lock", 1'b0, lock)
        tlp(1, 64'h100234);
        `CHK("fwd_addr", 64'h800234, faddr)
        `CHK("req_id", pid, rid)
        `CHK("snoop", 1'b1, sn)
        `CHK("four_dw", 1'b0, f4)
        acc(1, 1, 17'h10, 32'h001001FF);
        tlp(1, 64'h100234);
        `CHK("ur", 1'b1, ur)
        `CHK("no_fwd", 1'b0, fwd_v)
        tlp(1, 64'h1001FF);
        `CHK("at_limit", 1'b1, fwd_v)
        tlp(1, 64'h101000);
        `CHK("past_4k", 1'b1, ur)
        tlp(1, 64'hFF00000010);
        `CHK("big_addr", 64'h7F00000010, faddr)
        `CHK("big_4dw", 1'b1, f4)
        acc(1, 1, 17'h20, 32'h00500000);
        tlp(0, 64'h4ABCD);
        `CHK("pri_addr", 64'h50ABCD, faddr)
        `CHK("pri_id", sid, rid)
        acc(1, 1, 17'h13C, 32'hCAFEF00D);
        acc(0, 0, 17'h13C, 32'h0);
        `CHK("scratch", 32'hCAFEF00D, rd)
        `CHK("err", 1'b0, err)
        acc(0, 0, 17'h80, 32'h0);
        `CHK("sem_free", 32'h0, rd)
        acc(1, 0, 17'h80, 32'h0);
        `CHK("sem_owned", 32'h1, rd)
        acc(1, 1, 17'h100, 32'h55);
        acc(0, 0, 17'h100, 32'h0);
        `CHK("scratch_owned", 32'h55, rd)
        acc(0, 1, 17'h80, 32'h1);
        acc(1, 0, 17'h80, 32'h0);
        `CHK("sem_release", 32'h0, rd)
        acc(1, 1, 17'h60, 32'hFFFF);
        acc(0, 0, 17'h60, 32'h0);
        `CHK("pdb", 32'h3FFF, rd)
        `CHK("pirq", 1'b1, pirq)
        acc(0, 1, 17'h68, 32'h3FFF);
        `CHK("masked", 1'b0, pirq)
        acc(0, 1, 17'h60, 32'h3FFF);
        acc(0, 0, 17'h60, 32'h0);
        `CHK("pdb_clr", 32'h0, rd)
        @(negedge clk);
        flush_req = 1'b1;
        @(negedge clk);
        flush_req = 1'b0;
        acc(0, 0, 17'h60, 32'h0);
        `CHK("flush", 32'h4000, rd)
        `CHK("flush_irq", 1'b1, pirq)
        acc(0, 1, 17'h60, 32'h4000);
        train = 1'b1;
        repeat (8) @(negedge clk);
        acc(0, 0, 17'h60, 32'h0);
        `CHK("link_chg", 32'h8000, rd)
        acc(0, 1, 17'h64, 32'h1);
        `CHK("sirq", 1'b1, sirq)
        acc(1, 1, 17'h64, 32'h1);
        `CHK("sirq_clr", 1'b0, sirq)
        acc(1, 1, 17'h140, 32'hA5);
        `CHK("peer_v", 1'b1, pv)
        `CHK("peer_db", 64'h200060, paddr)
        `CHK("peer_data", 32'hA5, pdata)
        acc(0, 1, 17'h184, 32'h77);
        `CHK("peer_sp", 64'h200104, paddr)
        acc(1, 0, 17'h8000, 32'h0);
        `CHK("sec_range", 1'b1, err)
        give_verdict;
    end
endmodule
